// file: rtl/sft_map.svh
`ifndef SFT_MAP_SVH
`define SFT_MAP_SVH
// ****************************************************************
// register map
// ****************************************************************
`define SFT_ADDR_SETUP      4'h0
`define SFT_ADDR_TICK       4'h1
`define SFT_ADDR_STAT       4'h2
`define SFT_SETUP_RST       16'h0000
`define SFT_TICK_RST        3'h1
// ****************************************************************
// setup word fields
// ****************************************************************
`define SFT_F_FMT           15:14
`define SFT_F_LOW           13:12
`define SFT_B_CRC_LEGACY    11
`define SFT_B_STAT_CRC      10
`define SFT_B_WAKE_ZERO     9
`define SFT_B_ERR_STAT      6
`define SFT_B_FAST_ERR      5
`define SFT_B_SLOW_EN       4
`define SFT_F_BLOCKS        3:1
`define SFT_B_SDF           0
// ****************************************************************
// frame constants
// ****************************************************************
`define SFT_FMT_H2          2'h0
`define SFT_FMT_H4          2'h1
`define SFT_FMT_A1          2'h2
`define SFT_FMT_A7          2'h3
`define SFT_SYNC_TICKS      8'h38
`define SFT_NIB_BASE        8'h0c
`define SFT_LOW_BASE        8'h03
`define SFT_DATA_H2         3'h3
`define SFT_DATA_H1         3'h6
`define SFT_VAL_STARTUP     12'hffe
`define SFT_VAL_SENS_ERR    12'hffb
`define SFT_VAL_FUNC_ERR    12'hffa
`define SFT_CRC_SEED        4'h5
`define SFT_CRC_POLY        4'hd
// ****************************************************************
// tick times in ns, clock rate in MHz
// ****************************************************************
`define SFT_CLK_MHZ         50
`define SFT_TICK_NS_1       1500
`define SFT_TICK_NS_2       2000
`define SFT_TICK_NS_3       2500
`define SFT_TICK_NS_4       2750
`define SFT_TICK_NS_5       3000
`define SFT_TICK_NS_6       6000
`define SFT_TICK_NS_7       12000
`endif

// file: rtl/sft_pkg.sv
package sft_pkg;
    // frame sequencer states, gray along the frame
    typedef enum logic [2:0] {
        ST_SYNC   = 3'h0,
        ST_STATUS = 3'h1,
        ST_DATA   = 3'h3,
        ST_CRC    = 3'h2,
        ST_PAUSE  = 3'h6
    } sft_state_t;
    // sensor measurements and flags
    typedef struct packed {
        logic [11:0] pos;       // primary position
        logic [11:0] sec;       // temperature or field amplitude
        logic        startup;   // sensor still starting
        logic        sens_err;  // sensor error indication
        logic        func_err;  // functionality or processing error
    } sft_meas_t;
endpackage : sft_pkg

// file: rtl/sent_frame_transmitter.sv
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "sft_map.svh"
// What this block does
// - bits 15:14 pick one of four frame formats
// - bits 13:12 give low time 3..6 ticks
// - bit 11 picks 2010 or legacy CRC
// - bit 10 adds status nibble into CRC
// - bit 9 startup value 4094 or 0
// - bit 6 enables error bits in status
// - bit 5 enables fast channel error codes
// - bit 4 enables enhanced serial channel bits
// - block 1 always; bits 3:1 add blocks
// - bit 0 places diagnosis before block or ID
// - frames run continuously with no receiver input
// - sync, status, data, CRC, pause in order
// - status bits carry status and serial info
// - H.1 formats send six data nibbles
// - position sent MSN first in pulses 3..5
// - A.1 sends inverted position LSN first
// - A.7 sends second value LSN first
// - tick code picks tick length, 000 reserved
// - error codes 4091 and 4090 on channels
// - H.4 sends counter then inverted position MSN
module sent_frame_transmitter #(
    parameter int PAUSE_TICKS = 12
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [15:0]            reg_rdata,
    input  wire sft_pkg::sft_meas_t meas,
    input  wire logic              slow_bit2,
    input  wire logic              slow_bit3,
    output logic                   slow_take,
    output logic [3:0]             slow_blocks,
    output logic                   slow_diag_per_id,
    output logic                   sent_out
);
    // ****************************************************************
    // parameter check
    // ****************************************************************
    if (PAUSE_TICKS < 12 || PAUSE_TICKS > 255)
    begin : g_bad_pause
        $error("pause length must be 12 to 255 ticks");
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    // clock cycles per tick for a tick code, reserved code acts as 001
    function automatic logic [9:0] tick_cycles(input logic [2:0] code);
        int ns;
        case (code)
            3'h2:    ns = `SFT_TICK_NS_2;
            3'h3:    ns = `SFT_TICK_NS_3;
            3'h4:    ns = `SFT_TICK_NS_4;
            3'h5:    ns = `SFT_TICK_NS_5;
            3'h6:    ns = `SFT_TICK_NS_6;
            3'h7:    ns = `SFT_TICK_NS_7;
            default: ns = `SFT_TICK_NS_1;
        endcase
        return 10'(ns * `SFT_CLK_MHZ / 1000);
    endfunction : tick_cycles

    // one nibble through the four-bit SENT CRC, msb first
    function automatic logic [3:0] crc_nib(input logic [3:0] c, input logic [3:0] n);
        logic [3:0] r;
        logic       fb;
        r = c;
        for (int i = 3; i >= 0; i--)
        begin
            fb = r[3];
            r  = {r[2:0], n[i]} ^ (fb ? `SFT_CRC_POLY : 4'h0);
        end
        return r;
    endfunction : crc_nib

    // ****************************************************************
    // register file
    // ****************************************************************
    logic [15:0]        setup_reg,  setup_next;  // protocol setup word
    logic [2:0]         tick_reg,   tick_next;   // tick code
    logic [15:0]        rdata_reg,  rdata_next;  // read data, one cycle late
    logic [7:0]         frames_reg, frames_next; // frames sent, wraps
    sft_pkg::sft_state_t state_reg, state_next;  // frame sequencer

    // decode writes and reads
    always_comb
    begin
        setup_next = setup_reg;
        tick_next  = tick_reg;
        rdata_next = 16'h0000;
        if (reg_wr && reg_addr == `SFT_ADDR_SETUP)
        begin
            setup_next = reg_wdata;
        end
        else if (reg_wr && reg_addr == `SFT_ADDR_TICK)
        begin
            tick_next = reg_wdata[2:0];
        end
        if (reg_rd && reg_addr == `SFT_ADDR_SETUP)
        begin
            rdata_next = setup_reg;
        end
        else if (reg_rd && reg_addr == `SFT_ADDR_TICK)
        begin
            rdata_next = {13'h0000, tick_reg};
        end
        else if (reg_rd && reg_addr == `SFT_ADDR_STAT)
        begin
            rdata_next = {5'h00, state_reg, frames_reg};
        end
    end

    // register the file
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            setup_reg <= `SFT_SETUP_RST;
            tick_reg  <= `SFT_TICK_RST;
            rdata_reg <= 16'h0000;
        end
        else
        begin
            setup_reg <= setup_next;
            tick_reg  <= tick_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // slow channel block selection for the message builder
    assign slow_blocks      = {setup_reg[`SFT_F_BLOCKS], 1'b1};
    assign slow_diag_per_id = setup_reg[`SFT_B_SDF];

    // ****************************************************************
    // tick divider
    // ****************************************************************
    logic [9:0] div_reg, div_next;   // cycles into current tick
    logic       tick_en;             // one-cycle tick pulse

    // count cycles of one tick
    always_comb
    begin
        tick_en  = (div_reg >= tick_cycles(tick_reg) - 10'h001);
        div_next = tick_en ? 10'h000 : div_reg + 10'h001;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            div_reg <= 10'h000;
        end
        else
        begin
            div_reg <= div_next;
        end
    end

    // ****************************************************************
    // frame content
    // ****************************************************************
    logic [3:0]  nib_reg [0:6];      // status and data nibbles of frame
    logic [3:0]  nib_next [0:6];
    logic [2:0]  ndata_reg, ndata_next; // data nibbles in frame
    logic [7:0]  roll_reg, roll_next;   // rolling counter
    logic        scrc_reg, scrc_next;   // status nibble in CRC
    logic        legacy_reg, legacy_next; // legacy CRC method
    logic [3:0]  crc_val;               // CRC of latched frame
    logic [11:0] ch1;                   // channel 1 payload
    logic [11:0] ch2;                   // channel 2 payload
    logic [11:0] err_val;               // value replacing payload
    logic        err_sub;               // payload replaced
    logic        frame_start;           // last pause tick ends

    // build the next frame payload
    always_comb
    begin
        err_sub = 1'b0;
        err_val = 12'h000;
        if (meas.startup)
        begin
            err_sub = 1'b1;
            err_val = setup_reg[`SFT_B_WAKE_ZERO] ? 12'h000 : `SFT_VAL_STARTUP;
        end
        else if (setup_reg[`SFT_B_FAST_ERR] && meas.sens_err)
        begin
            err_sub = 1'b1;
            err_val = `SFT_VAL_SENS_ERR;
        end
        else if (setup_reg[`SFT_B_FAST_ERR] && meas.func_err)
        begin
            err_sub = 1'b1;
            err_val = `SFT_VAL_FUNC_ERR;
        end
        ch1 = err_sub ? err_val : meas.pos;
        case (setup_reg[`SFT_F_FMT])
            `SFT_FMT_H4: ch2 = {roll_reg, ~ch1[11:8]};
            `SFT_FMT_A1: ch2 = err_sub ? err_val : ~meas.pos;
            `SFT_FMT_A7: ch2 = err_sub ? err_val : meas.sec;
            default:     ch2 = 12'h000;
        endcase
        for (int i = 0; i < 7; i++)
        begin
            nib_next[i] = nib_reg[i];
        end
        ndata_next  = ndata_reg;
        scrc_next   = scrc_reg;
        legacy_next = legacy_reg;
        roll_next   = roll_reg;
        if (frame_start)
        begin
            nib_next[0][1:0] = setup_reg[`SFT_B_ERR_STAT] ?
                               {meas.func_err, meas.sens_err} : 2'h0;
            nib_next[0][3:2] = setup_reg[`SFT_B_SLOW_EN] ?
                               {slow_bit3, slow_bit2} : 2'h0;
            nib_next[1] = ch1[11:8];
            nib_next[2] = ch1[7:4];
            nib_next[3] = ch1[3:0];
            if (setup_reg[`SFT_F_FMT] == `SFT_FMT_H4)
            begin
                nib_next[4] = ch2[11:8];
                nib_next[5] = ch2[7:4];
                nib_next[6] = ch2[3:0];
            end
            else
            begin
                nib_next[4] = ch2[3:0];
                nib_next[5] = ch2[7:4];
                nib_next[6] = ch2[11:8];
            end
            ndata_next  = (setup_reg[`SFT_F_FMT] == `SFT_FMT_H2) ?
                          `SFT_DATA_H2 : `SFT_DATA_H1;
            scrc_next   = setup_reg[`SFT_B_STAT_CRC];
            legacy_next = setup_reg[`SFT_B_CRC_LEGACY];
            roll_next   = roll_reg + 8'h01;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < 7; i++)
            begin
                nib_reg[i] <= 4'h0;
            end
            ndata_reg  <= `SFT_DATA_H2;
            scrc_reg   <= 1'b0;
            legacy_reg <= 1'b0;
            roll_reg   <= 8'h00;
        end
        else
        begin
            nib_reg    <= nib_next;
            ndata_reg  <= ndata_next;
            scrc_reg   <= scrc_next;
            legacy_reg <= legacy_next;
            roll_reg   <= roll_next;
        end
    end

    // CRC over the latched frame in send order
    always_comb
    begin
        crc_val = `SFT_CRC_SEED;
        if (scrc_reg)
        begin
            crc_val = crc_nib(crc_val, nib_reg[0]);
        end
        for (int i = 1; i < 7; i++)
        begin
            if (3'(i) <= ndata_reg)
            begin
                crc_val = crc_nib(crc_val, nib_reg[i]);
            end
        end
        if (!legacy_reg)
        begin
            crc_val = crc_nib(crc_val, 4'h0);
        end
    end

    // ****************************************************************
    // pulse sequencer
    // ****************************************************************
    logic [7:0] tcnt_reg, tcnt_next;   // ticks into current pulse
    logic [2:0] didx_reg, didx_next;   // data nibble index
    logic       line_reg, line_next;   // line level
    logic [7:0] plen;                  // current pulse length in ticks
    logic [7:0] low_ticks;             // low phase in ticks
    logic       pend;                  // last tick of pulse

    // pulse length and next position, free running
    always_comb
    begin
        low_ticks = `SFT_LOW_BASE + 8'(setup_reg[`SFT_F_LOW]);
        case (state_reg)
            sft_pkg::ST_SYNC:   plen = `SFT_SYNC_TICKS;
            sft_pkg::ST_STATUS: plen = `SFT_NIB_BASE + 8'(nib_reg[0]);
            sft_pkg::ST_DATA:   plen = `SFT_NIB_BASE + 8'(nib_reg[didx_reg]);
            sft_pkg::ST_CRC:    plen = `SFT_NIB_BASE + 8'(crc_val);
            default:            plen = 8'(PAUSE_TICKS);
        endcase
        pend        = tick_en && (tcnt_reg == plen - 8'h01);
        frame_start = pend && (state_reg == sft_pkg::ST_PAUSE);
        state_next  = state_reg;
        didx_next   = didx_reg;
        tcnt_next   = tick_en ? (pend ? 8'h00 : tcnt_reg + 8'h01) : tcnt_reg;
        frames_next = frames_reg;
        if (pend)
        begin
            case (state_reg)
                sft_pkg::ST_SYNC:   state_next = sft_pkg::ST_STATUS;
                sft_pkg::ST_STATUS:
                begin
                    state_next = sft_pkg::ST_DATA;
                    didx_next  = 3'h1;
                end
                sft_pkg::ST_DATA:
                begin
                    if (didx_reg == ndata_reg)
                    begin
                        state_next = sft_pkg::ST_CRC;
                    end
                    else
                    begin
                        didx_next = didx_reg + 3'h1;
                    end
                end
                sft_pkg::ST_CRC:
                begin
                    state_next  = sft_pkg::ST_PAUSE;
                    frames_next = frames_reg + 8'h01;
                end
                default:            state_next = sft_pkg::ST_SYNC;
            endcase
        end
        line_next = (tcnt_next >= low_ticks);
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_reg  <= sft_pkg::ST_PAUSE;
            tcnt_reg   <= 8'h00;
            didx_reg   <= 3'h1;
            line_reg   <= 1'b1;
            frames_reg <= 8'h00;
        end
        else
        begin
            state_reg  <= state_next;
            tcnt_reg   <= tcnt_next;
            didx_reg   <= didx_next;
            line_reg   <= line_next;
            frames_reg <= frames_next;
        end
    end

    assign sent_out  = line_reg;
    assign slow_take = frame_start;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_sync_end;
        pend && state_reg == sft_pkg::ST_SYNC;
    endsequence
    sequence s_status_go;
        state_reg == sft_pkg::ST_STATUS && tcnt_reg == 8'h00;
    endsequence

    property p_order;
        s_sync_end |=> s_status_go;
    endproperty
    a_order: assert property (p_order) else $error("status must follow sync");

    property p_low;
        tick_en && tcnt_reg == 8'h00 |=> !sent_out;
    endproperty
    a_low: assert property (p_low) else $error("pulse must start low");

    property p_lowlen;
        tick_en && tcnt_next == low_ticks |=> sent_out;
    endproperty
    a_lowlen: assert property (p_lowlen) else $error("low phase length wrong");

    property p_sync_len;
        state_reg == sft_pkg::ST_SYNC && pend |-> tcnt_reg == `SFT_SYNC_TICKS - 8'h01;
    endproperty
    a_sync_len: assert property (p_sync_len) else $error("sync not 56 ticks");

    property p_ndata;
        frame_start |=> ndata_reg == (($past(setup_reg[`SFT_F_FMT]) == `SFT_FMT_H2) ?
                                      `SFT_DATA_H2 : `SFT_DATA_H1);
    endproperty
    a_ndata: assert property (p_ndata) else $error("data nibble count wrong");

    property p_pos_msn;
        frame_start && !err_sub |=> nib_reg[1] == $past(meas.pos[11:8]);
    endproperty
    a_pos_msn: assert property (p_pos_msn) else $error("position msn wrong");

    property p_a1;
        frame_start && !err_sub && setup_reg[15:14] == 2'h2
            |=> nib_reg[4] == ~$past(meas.pos[3:0]) && nib_reg[6] == ~$past(meas.pos[11:8]);
    endproperty
    a_a1: assert property (p_a1) else $error("inverse channel wrong");

    property p_wake;
        frame_start && meas.startup && !setup_reg[9]
            |=> {nib_reg[1], nib_reg[2], nib_reg[3]} == 12'hffe;
    endproperty
    a_wake: assert property (p_wake) else $error("startup value wrong");

    property p_stat0;
        frame_start && !setup_reg[6] |=> nib_reg[0][1:0] == 2'h0;
    endproperty
    a_stat0: assert property (p_stat0) else $error("status error bits set");

    property p_roll;
        frame_start |=> roll_reg == $past(roll_reg) + 8'h01;
    endproperty
    a_roll: assert property (p_roll) else $error("rolling counter stuck");
endmodule : sent_frame_transmitter

// file: verification/sft_sent_rx.sv
`timescale 1ns/1ps
// ****************************************************************
// listen-only receiver: splits the line into pulses between falls
// ****************************************************************
module sft_sent_rx #(
    parameter int TICK_CYC = 75
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sent_line  // input only, never driven back
);
    logic       prev;         // line level one cycle ago
    int         cyc;          // cycles since last fall
    int         low_cyc;      // low cycles of current pulse
    int         ticks;        // rounded length of closed pulse
    int         low_ticks;    // low ticks of last closed pulse
    int         cnt;          // nibbles since last sync
    int         sync_cyc;     // cycles of last sync, 56 ticks long
    int         syncs;        // sync pulses seen
    logic [3:0] nib [0:15];   // nibbles of current frame

    // measure each pulse at the fall that closes it
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            prev  <= 1'b1;
            cnt   <= 0;
            syncs <= 0;
            sync_cyc <= TICK_CYC * 56;
        end
        else
        begin
            prev <= sent_line;
            cyc  <= cyc + 1;
            if (!sent_line)
                low_cyc <= low_cyc + 1;
            if (prev && !sent_line)
            begin
                // lengths scaled by the last sync pulse, as a receiver calibrates
                ticks = (cyc * 56 + sync_cyc / 2) / sync_cyc;
                low_ticks <= (low_cyc * 56 + sync_cyc / 2) / sync_cyc;
                cyc       <= 1;
                low_cyc   <= 1;
                // 56 ticks calibrates and opens a frame
                if (ticks == 56)
                begin
                    cnt   <= 0;
                    syncs <= syncs + 1;
                    sync_cyc <= cyc;
                end
                // nibble is length less 12 ticks
                else if (cnt < 16 && ticks >= 12 && ticks <= 27)
                begin
                    nib[cnt] <= 4'(ticks - 12);
                    cnt      <= cnt + 1;
                end
            end
        end
    end
endmodule : sft_sent_rx

// file: verification/tb_sent_frame_transmitter.sv
`timescale 1ns/1ps
module tb_sent_frame_transmitter;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic               core_clk    = 1'b0;
    logic               rst         = 1'b1;
    logic [3:0]         reg_addr    = 4'h0;
    logic [15:0]        reg_wdata   = 16'h0000;
    logic               reg_wr      = 1'b0;
    logic               reg_rd      = 1'b0;
    logic [15:0]        reg_rdata;
    sft_pkg::sft_meas_t meas        = '0;
    logic               slow_bit2   = 1'b0;
    logic               slow_bit3   = 1'b0;
    logic               slow_take;
    logic [3:0]         slow_blocks;
    logic               slow_diag_per_id;
    logic               sent_out;
    int                 error_cnt   = 0;  // mismatches
    int                 check_count = 0;  // comparisons
    int                 take_cnt    = 0;  // payload latch pulses

    // 50 MHz clock
    always #10 core_clk = ~core_clk;

    // count latch pulses mid-cycle where they are settled
    always @(negedge core_clk)
    begin
        if (slow_take === 1'b1)
            take_cnt++;
    end

    sent_frame_transmitter #(.PAUSE_TICKS(12)) sent_frame_transmitter_i (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas(meas),
        .slow_bit2(slow_bit2), .slow_bit3(slow_bit3), .slow_take(slow_take),
        .slow_blocks(slow_blocks), .slow_diag_per_id(slow_diag_per_id), .sent_out(sent_out)
    );

    // tick code 1 is 1.5 us, 75 clocks
    sft_sent_rx #(.TICK_CYC(75)) sft_sent_rx_i (
        .core_clk(core_clk), .rst(rst), .sent_line(sent_out)
    );

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic reg_write(input logic [3:0] addr, input logic [15:0] data);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= addr;
        reg_wdata <= data;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] addr, output logic [15:0] data);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= addr;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 data = reg_rdata;
    endtask : reg_read

    // one nibble through the crc, shifting data in msb first
    function automatic logic [3:0] crc_step(input logic [3:0] c, input logic [3:0] n);
        logic fb;
        for (int b = 3; b >= 0; b--)
        begin
            fb = c[3];
            c  = {c[2:0], n[b]};
            if (fb)
                c = c ^ 4'hd;
        end
        return c;
    endfunction : crc_step

    // channel value after start-up and error substitution
    function automatic logic [11:0] chan(input logic [15:0] s, input sft_pkg::sft_meas_t m,
                                         input logic [11:0] v);
        if (m.startup)
            return s[9] ? 12'h000 : 12'hffe;
        if (s[5] && m.sens_err)
            return 12'hffb;
        if (s[5] && m.func_err)
            return 12'hffa;
        return v;
    endfunction : chan

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic test_registers();
        logic [15:0] d;
        reg_read(4'h1, d);
        check("tick code reset", d, 16'h0001);
        reg_write(4'h1, 16'hfff6);
        reg_read(4'h1, d);
        check("tick code write", d, 16'h0006);
        reg_write(4'h1, 16'h0001);
        reg_read(4'h2, d);
        check("status after reset", d, 16'h0600);
        reg_write(4'h2, 16'hffff);
        reg_read(4'h2, d);
        check("status read only", d, 16'h0600);
        reg_read(4'hf, d);
        check("unmapped read", d, 16'h0000);
        reg_write(4'h0, 16'ha5c3);
        reg_read(4'h0, d);
        check("setup readback", d, 16'ha5c3);
        @(posedge core_clk);
        #1 check("read data one cycle", reg_rdata, 16'h0000);
    endtask : test_registers

    // configure during the pause, then judge the next whole frame
    task automatic run_frame(input string name, input logic [15:0] s,
                             input sft_pkg::sft_meas_t m, input logic b2, input logic b3);
        logic [3:0]  exp [0:9];
        logic [11:0] c1;
        logic [11:0] c2;
        logic [7:0]  ctr;
        int          nd;
        int          s0;
        int          k;
        reg_write(4'h0, s);
        meas      <= m;
        slow_bit2 <= b2;
        slow_bit3 <= b3;
        s0  = sft_sent_rx_i.syncs;
        ctr = 8'(s0);  // counter sent equals frames started before this one
        c1  = chan(s, m, m.pos);
        exp[0] = {s[4] ? {b3, b2} : 2'b00, s[6] ? {m.func_err, m.sens_err} : 2'b00};
        {exp[1], exp[2], exp[3]} = c1;
        nd = (s[15:14] == 2'h0) ? 3 : 6;
        c2 = chan(s, m, (s[15:14] == 2'h2) ? ~m.pos : m.sec);
        {exp[6], exp[5], exp[4]} = c2;
        if (s[15:14] == 2'h1)
            {exp[4], exp[5], exp[6]} = {ctr, ~c1[11:8]};
        exp[nd + 1] = 4'h5;
        for (int i = s[10] ? 0 : 1; i <= nd; i++)
            exp[nd + 1] = crc_step(exp[nd + 1], exp[i]);
        if (!s[11])
            exp[nd + 1] = crc_step(exp[nd + 1], 4'h0);
        k = 0;
        while ((sft_sent_rx_i.syncs == s0 || sft_sent_rx_i.cnt != nd + 2) && k < 60000)
        begin
            @(posedge core_clk);
            k++;
        end
        check({name, " frame seen"}, 16'(k < 60000), 16'h0001);
        check({name, " status"}, 16'(sft_sent_rx_i.nib[0]), 16'(exp[0]));
        for (int i = 1; i <= nd; i++)
            check($sformatf("%s data %0d", name, i), 16'(sft_sent_rx_i.nib[i]),
                  16'(exp[i]));
        check({name, " crc"}, 16'(sft_sent_rx_i.nib[nd + 1]), 16'(exp[nd + 1]));
        check({name, " low"}, 16'(sft_sent_rx_i.low_ticks), 16'(3 + s[13:12]));
        check({name, " blocks"}, 16'(slow_blocks), {12'h000, s[3:1], 1'b1});
        check({name, " diag"}, 16'(slow_diag_per_id), 16'(s[0]));
    endtask : run_frame

    task automatic final_report();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial
    begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        test_registers();
        run_frame("h2 wake", 16'h0000, {12'h123, 12'h000, 3'b110}, 1'b1, 1'b1);
        run_frame("a1", 16'h9453, {12'h3a5, 12'h000, 3'b010}, 1'b1, 1'b0);
        run_frame("a7", 16'he82c, {12'h81e, 12'h5c7, 3'b000}, 1'b0, 1'b1);
        run_frame("h4", 16'h727f, {12'h0f0, 12'h000, 3'b011}, 1'b0, 1'b1);
        run_frame("h2 zero", 16'h0200, {12'hfff, 12'h000, 3'b100}, 1'b0, 1'b0);
        check("latch pulses", 16'(take_cnt), 16'h0005);
        final_report();
    end

    initial
    begin
        #1900000;
        error_cnt++;
        final_report();
    end
endmodule : tb_sent_frame_transmitter
